// ### hw/tsi_i2c_slave.sv
// Purpose: Slave side serial register port of a capacitive touch controller.
// Assumes: The bus is oversampled by clk_i at 25 MHz; pins pass two flops first.
// Notes: Data line is open drain: sda_oe_o high pulls the line low via sda_o.

// How it works
// - Only answers; never starts a bus transfer.
// - Oversampling keeps up with 400 kbit/s.
// - Answers 0xBA/0xBB or 0x28/0x29 pair.
// - Pair chosen from lines at touch reset.
// - Matching address acknowledged low on ninth clock.
// - Mismatch leaves device idle and silent.
// - Each unit is eight bits plus acknowledge.
// - Data line changes only while clock low.
// - Pointer steps by one per written byte.
// - Read returns consecutive bytes while acknowledged.
// - Configuration version byte at 0x8047.
// - X and Y maxima as byte pairs.
module tsi_i2c_slave (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Address select pins
  input wire logic touch_reset_line_n_i,
  input wire logic int_i,
  output logic int_o,
  output logic int_oe_o,
  // Register contents
  output logic [7:0] command_o,
  output logic [7:0] config_version_o,
  output logic [15:0] x_max_o,
  output logic [15:0] y_max_o,
  output logic [3:0] touch_point_limit_o,
  output logic swap_axes_o,
  output logic addr_sel_o
);

  // =====================================================================
  // Pin synchronisers.
  logic scl_s;
  logic sda_s;
  logic trst_n_s;
  logic int_s;
  logic scl_d_q;
  logic sda_d_q;
  logic trst_n_d_q;

  tsi_sync2 u_sync_scl (.clk_i(clk_i), .srst_i(srst_i), .async_i(scl_i), .sync_o(scl_s));
  tsi_sync2 u_sync_sda (.clk_i(clk_i), .srst_i(srst_i), .async_i(sda_i), .sync_o(sda_s));
  tsi_sync2 u_sync_trst (.clk_i(clk_i), .srst_i(srst_i), .async_i(touch_reset_line_n_i),
                         .sync_o(trst_n_s));
  tsi_sync2 u_sync_int (.clk_i(clk_i), .srst_i(srst_i), .async_i(int_i), .sync_o(int_s));

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
      trst_n_d_q <= 1'b1;
    end else begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
      trst_n_d_q <= trst_n_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic trst_release;

  // Edge detection runs at 62 clocks per bit at the top bus rate.
  assign scl_rise = scl_s && !scl_d_q;
  assign scl_fall = !scl_s && scl_d_q;
  assign start_det = scl_s && scl_d_q && !sda_s && sda_d_q;
  assign stop_det = scl_s && scl_d_q && sda_s && !sda_d_q;
  assign trst_release = trst_n_s && !trst_n_d_q;

  // =====================================================================
  // Slave address selection.
  logic addr_sel_q;
  logic [7:0] own_addr;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      addr_sel_q <= 1'b0;
    end else if (trst_release) begin
      addr_sel_q <= int_s;
    end
  end

  assign own_addr = addr_sel_q ? tsi_pkg::ADDR_PAIR_B : tsi_pkg::ADDR_PAIR_A;
  assign addr_sel_o = addr_sel_q;
  // The interrupt pin is only a select input here; it is never driven.
  assign int_o = 1'b0;
  assign int_oe_o = 1'b0;

  // =====================================================================
  // Byte engine.
  tsi_pkg::tsi_state_type state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [1:0] byte_pos_q;
  logic read_q;
  logic mack_q;
  logic [15:0] ptr_q;
  logic drive_low_q;
  logic byte_done;
  logic addr_match;
  logic wr_en;
  logic load_rd;
  logic [7:0] rd_data;

  assign byte_done = (state_q == tsi_pkg::ST_RECV) && scl_fall &&
                     (bit_cnt_q == tsi_pkg::BITS_PER_BYTE);
  assign addr_match = (shift_q[7:1] == own_addr[7:1]);
  assign wr_en = byte_done && (byte_pos_q == tsi_pkg::BYTE_DATA) && !read_q;
  // A byte is fetched when the read address is acknowledged and after each master ack.
  assign load_rd = scl_fall && !start_det && !stop_det &&
                   (((state_q == tsi_pkg::ST_ACK) && read_q) ||
                    ((state_q == tsi_pkg::ST_RACK) && mack_q));

  always_ff @(posedge clk_i) begin
    if (srst_i || !trst_n_s) begin
      state_q <= tsi_pkg::ST_IDLE;
    end else if (start_det) begin
      state_q <= tsi_pkg::ST_RECV;
    end else if (stop_det) begin
      state_q <= tsi_pkg::ST_IDLE;
    end else if (scl_fall) begin
      case (state_q)
        tsi_pkg::ST_RECV: begin
          if (bit_cnt_q == tsi_pkg::BITS_PER_BYTE) begin
            if ((byte_pos_q == tsi_pkg::BYTE_ADDR) && !addr_match) begin
              state_q <= tsi_pkg::ST_IDLE;
            end else begin
              state_q <= tsi_pkg::ST_ACK;
            end
          end
        end
        tsi_pkg::ST_ACK: begin
          state_q <= read_q ? tsi_pkg::ST_SEND : tsi_pkg::ST_RECV;
        end
        tsi_pkg::ST_SEND: begin
          if (bit_cnt_q == tsi_pkg::LAST_SEND_BIT) begin
            state_q <= tsi_pkg::ST_RACK;
          end
        end
        tsi_pkg::ST_RACK: begin
          state_q <= mack_q ? tsi_pkg::ST_SEND : tsi_pkg::ST_IDLE;
        end
        default: begin
          state_q <= tsi_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Bit counting and shifting.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bit_cnt_q <= '0;
      shift_q <= '0;
    end else if (start_det) begin
      bit_cnt_q <= '0;
    end else if (load_rd) begin
      bit_cnt_q <= '0;
      shift_q <= rd_data;
    end else if ((state_q == tsi_pkg::ST_ACK) && scl_fall) begin
      bit_cnt_q <= '0;
    end else if ((state_q == tsi_pkg::ST_RECV) && scl_rise) begin
      bit_cnt_q <= bit_cnt_q + tsi_pkg::BIT_ONE;
      shift_q <= {shift_q[6:0], sda_s};
    end else if ((state_q == tsi_pkg::ST_SEND) && scl_fall) begin
      bit_cnt_q <= bit_cnt_q + tsi_pkg::BIT_ONE;
      shift_q <= {shift_q[6:0], 1'b0};
    end
  end

  // Transaction position, direction and master acknowledge.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      byte_pos_q <= tsi_pkg::BYTE_ADDR;
      read_q <= 1'b0;
      mack_q <= 1'b0;
    end else if (start_det) begin
      byte_pos_q <= tsi_pkg::BYTE_ADDR;
      read_q <= 1'b0;
    end else if (byte_done) begin
      if (byte_pos_q == tsi_pkg::BYTE_ADDR) begin
        read_q <= shift_q[0];
      end
      if (byte_pos_q != tsi_pkg::BYTE_DATA) begin
        byte_pos_q <= byte_pos_q + 2'h1;
      end
    end else if ((state_q == tsi_pkg::ST_RACK) && scl_rise) begin
      mack_q <= !sda_s;
    end
  end

  // Register pointer.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ptr_q <= tsi_pkg::REG_BASE;
    end else if (byte_done && !read_q && (byte_pos_q == tsi_pkg::BYTE_REG_HIGH)) begin
      ptr_q[15:8] <= shift_q;
    end else if (byte_done && !read_q && (byte_pos_q == tsi_pkg::BYTE_REG_LOW)) begin
      ptr_q[7:0] <= shift_q;
    end else if (wr_en || load_rd) begin
      ptr_q <= ptr_q + tsi_pkg::PTR_STEP;
    end
  end

  // Data line drive: changed only on a clock fall or when the transfer ends.
  always_ff @(posedge clk_i) begin
    if (srst_i || !trst_n_s) begin
      drive_low_q <= 1'b0;
    end else if (start_det || stop_det) begin
      drive_low_q <= 1'b0;
    end else if (load_rd) begin
      drive_low_q <= !rd_data[7];
    end else if (byte_done) begin
      drive_low_q <= (byte_pos_q != tsi_pkg::BYTE_ADDR) || addr_match;
    end else if (scl_fall) begin
      if ((state_q == tsi_pkg::ST_SEND) && (bit_cnt_q != tsi_pkg::LAST_SEND_BIT)) begin
        drive_low_q <= !shift_q[6];
      end else begin
        drive_low_q <= 1'b0;
      end
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = drive_low_q;

  // =====================================================================
  // Registers.
  tsi_regfile u_regs (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .wr_en_i(wr_en),
    .addr_i(ptr_q),
    .wr_data_i(shift_q),
    .rd_data_o(rd_data),
    .command_o(command_o),
    .config_version_o(config_version_o),
    .x_max_o(x_max_o),
    .y_max_o(y_max_o),
    .touch_point_limit_o(touch_point_limit_o),
    .swap_axes_o(swap_axes_o)
  );

  // =====================================================================
  // Checks.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  a_idle_no_drive: assert property (
    (state_q == tsi_pkg::ST_IDLE) && $past(state_q == tsi_pkg::ST_IDLE) |-> !sda_oe_o)
    else $error("Data line driven while idle");

  a_ack_on_match: assert property (
    byte_done && (byte_pos_q == tsi_pkg::BYTE_ADDR) && addr_match
    |=> sda_oe_o && !sda_o && (state_q == tsi_pkg::ST_ACK))
    else $error("Matching address not acknowledged");

  a_nomatch_idle: assert property (
    byte_done && (byte_pos_q == tsi_pkg::BYTE_ADDR) && !addr_match && !start_det
    |=> (state_q == tsi_pkg::ST_IDLE) && !sda_oe_o)
    else $error("Mismatched address not ignored");

  a_drive_scl_low: assert property (
    $changed(sda_oe_o) && !$past(start_det) && !$past(stop_det) |-> !$past(scl_s))
    else $error("Data line changed while clock high");

  a_write_step: assert property (
    wr_en |=> (ptr_q == $past(ptr_q) + tsi_pkg::PTR_STEP))
    else $error("Pointer did not step after write");

  a_read_step: assert property (
    load_rd |=> (ptr_q == $past(ptr_q) + tsi_pkg::PTR_STEP) && (shift_q == $past(rd_data)))
    else $error("Read byte not fetched from pointer");

  a_addr_latch: assert property (
    trst_release && !srst_i |=> (addr_sel_q == $past(int_s)))
    else $error("Address select not latched at release");

  a_nine_clocks: assert property (
    (state_q == tsi_pkg::ST_ACK) && scl_fall && !read_q && !start_det && !stop_det
    |=> (state_q == tsi_pkg::ST_RECV) && (bit_cnt_q == 4'h0))
    else $error("Byte framing not restarted after acknowledge");

  a_nack_ends: assert property (
    (state_q == tsi_pkg::ST_RACK) && !mack_q && scl_fall && !start_det
    |=> (state_q == tsi_pkg::ST_IDLE) [*2])
    else $error("Read not ended by master nack");

  c_write_byte: cover property (wr_en);
  c_read_byte: cover property (load_rd ##[1:1000] (state_q == tsi_pkg::ST_RACK));
  c_mismatch: cover property (byte_done && (byte_pos_q == tsi_pkg::BYTE_ADDR) && !addr_match);
  c_alt_addr: cover property (addr_sel_q && byte_done && addr_match);

endmodule

// ### hw/tsi_regfile.sv
// Purpose: Byte register file for the real-time command and first configuration bytes.
// Assumes: Write and read address come from the serial engine on the same clock.
// Notes: The command byte is write only and reads as zero; unmapped bytes read zero.

module tsi_regfile (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Access port
  input wire logic wr_en_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] rd_data_o,
  // Register contents
  output logic [7:0] command_o,
  output logic [7:0] config_version_o,
  output logic [15:0] x_max_o,
  output logic [15:0] y_max_o,
  output logic [3:0] touch_point_limit_o,
  output logic swap_axes_o
);

  logic [7:0] mem_q [tsi_pkg::REG_COUNT];
  logic in_range;
  logic [3:0] idx;

  assign in_range = (addr_i >= tsi_pkg::REG_BASE) && (addr_i <= tsi_pkg::REG_LAST);
  assign idx = 4'(addr_i - tsi_pkg::REG_BASE);

  // =====================================================================
  // Storage.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < tsi_pkg::REG_COUNT; i++) begin
        mem_q[i] <= tsi_pkg::REG_RESET;
      end
    end else if (wr_en_i && in_range) begin
      mem_q[idx] <= wr_data_i;
    end
  end

  always_comb begin
    rd_data_o = tsi_pkg::READ_ZERO;
    if (in_range && (addr_i != tsi_pkg::REG_COMMAND)) begin
      rd_data_o = mem_q[idx];
    end
  end

  assign command_o = mem_q[4'(tsi_pkg::REG_COMMAND - tsi_pkg::REG_BASE)];
  assign config_version_o = mem_q[4'(tsi_pkg::REG_CONFIG_VERSION - tsi_pkg::REG_BASE)];
  assign x_max_o = {mem_q[4'(tsi_pkg::REG_X_MAX_HIGH - tsi_pkg::REG_BASE)],
                    mem_q[4'(tsi_pkg::REG_X_MAX_LOW - tsi_pkg::REG_BASE)]};
  assign y_max_o = {mem_q[4'(tsi_pkg::REG_Y_MAX_HIGH - tsi_pkg::REG_BASE)],
                    mem_q[4'(tsi_pkg::REG_Y_MAX_LOW - tsi_pkg::REG_BASE)]};
  assign touch_point_limit_o =
    mem_q[4'(tsi_pkg::REG_TOUCH_POINT_LIMIT - tsi_pkg::REG_BASE)][tsi_pkg::TOUCH_LIMIT_MSB:0];
  assign swap_axes_o =
    mem_q[4'(tsi_pkg::REG_MODULE_OPTIONS_ONE - tsi_pkg::REG_BASE)][tsi_pkg::SWAP_AXES_BIT];

  // =====================================================================
  // Checks.
  a_x_low_store: assert property (@(posedge clk_i) disable iff (srst_i)
    (wr_en_i && addr_i == tsi_pkg::REG_X_MAX_LOW) |=> (x_max_o[7:0] == $past(wr_data_i)))
    else $error("X maximum low byte not stored");

endmodule

// ### hw/tsi_sync2.sv
// Purpose: Two-flop synchroniser for one pin input.
// Assumes: The input is asynchronous to clk_i.
// Notes: The first flop feeds only the second flop.

module tsi_sync2 (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Pin side
  input wire logic async_i,
  output logic sync_o
);

  logic meta_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_q <= 1'b1;
      sync_o <= 1'b1;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// ### inc/tsi_pkg.sv
// Purpose: Shared constants and types for the touch controller serial register port.
// Assumes: One 25 MHz clock; bus pins are oversampled through two-flop synchronisers.
// Notes: Register indexes are the 16-bit register addresses seen on the serial bus.

// =====================================================================
// Package
package tsi_pkg;

  // =====================================================================
  // Slave address pairs, compared on the upper seven bits only; the R/W bit is ignored.
  localparam logic [7:0] ADDR_PAIR_A = 8'hba;
  localparam logic [7:0] ADDR_PAIR_B = 8'h28;

  // =====================================================================
  // Register map.
  localparam logic [15:0] REG_BASE = 16'h8040;
  localparam logic [15:0] REG_COMMAND = 16'h8040;
  localparam logic [15:0] REG_CONFIG_VERSION = 16'h8047;
  localparam logic [15:0] REG_X_MAX_LOW = 16'h8048;
  localparam logic [15:0] REG_X_MAX_HIGH = 16'h8049;
  localparam logic [15:0] REG_Y_MAX_LOW = 16'h804a;
  localparam logic [15:0] REG_Y_MAX_HIGH = 16'h804b;
  localparam logic [15:0] REG_TOUCH_POINT_LIMIT = 16'h804c;
  localparam logic [15:0] REG_MODULE_OPTIONS_ONE = 16'h804d;
  localparam logic [15:0] REG_LAST = 16'h804d;
  localparam int REG_COUNT = 14;

  // Reset values are not given by the part; zero is used for all.
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // Field positions.
  localparam int SWAP_AXES_BIT = 3;
  localparam int TOUCH_LIMIT_MSB = 3;

  // =====================================================================
  // Byte framing.
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_SEND_BIT = 4'h7;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [15:0] PTR_STEP = 16'h0001;

  // Position of the current byte within a transaction.
  localparam logic [1:0] BYTE_ADDR = 2'h0;
  localparam logic [1:0] BYTE_REG_HIGH = 2'h1;
  localparam logic [1:0] BYTE_REG_LOW = 2'h2;
  localparam logic [1:0] BYTE_DATA = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RECV = 3'h1,
    ST_ACK = 3'h2,
    ST_SEND = 3'h3,
    ST_RACK = 3'h4
  } tsi_state_type;

endpackage

// ### tb/tsi_i2c_slave_test.sv
// Purpose: Self-checking bench for the touch controller serial register port.
// Assumes: 25 MHz clock; bus bit period 320 ns from the master model.
// Notes: Only mismatches and the verdict are printed.

module tsi_i2c_slave_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i, srst_i, rst_line_n, int_drive, int_val, prev_scl, prev_oe, seen_oe;
  logic scl_line, sda_low, sda_o, sda_oe_o, int_o, int_oe_o, swap_axes_o, addr_sel_o;
  logic [7:0] command_o, config_version_o;
  logic [15:0] x_max_o, y_max_o;
  logic [3:0] touch_point_limit_o;
  wire logic sda_line = !(sda_low || (sda_oe_o && !sda_o));
  wire logic int_line = int_oe_o ? int_o : (int_drive ? int_val : !int_val);
  int n_mismatch = 0;
  int n_compared = 0;

  tsi_master_model master (.clk_i(clk_i), .sda_line_i(sda_line), .scl_o(scl_line),
    .sda_low_o(sda_low));

  tsi_i2c_slave DUT (.clk_i(clk_i), .srst_i(srst_i), .scl_i(scl_line), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .touch_reset_line_n_i(rst_line_n), .int_i(int_line),
    .int_o(int_o), .int_oe_o(int_oe_o), .command_o(command_o),
    .config_version_o(config_version_o), .x_max_o(x_max_o), .y_max_o(y_max_o),
    .touch_point_limit_o(touch_point_limit_o), .swap_axes_o(swap_axes_o),
    .addr_sel_o(addr_sel_o));

  always #20 clk_i = ~clk_i;

  // =====================================================================
  // Checking

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // The device may only change the data line while the clock is low.
  always @(posedge clk_i) begin
    if (scl_line && prev_scl && !srst_i) check(sda_oe_o, prev_oe);
    if (sda_oe_o) seen_oe = 1'b1;
    prev_scl <= scl_line;
    prev_oe <= sda_oe_o;
  end

  // =====================================================================
  // Bus sequences

  task automatic write_seq(input logic [7:0] aw, input logic [15:0] ptr,
                           input logic [7:0] d[$], input logic exp_ack);
    logic a;
    master.bus_start();
    master.send_byte(aw, a);
    check(a, exp_ack);
    // A slave that was not addressed must stay silent for the rest of the transfer.
    master.send_byte(ptr[15:8], a);
    check(a, exp_ack);
    master.send_byte(ptr[7:0], a);
    check(a, exp_ack);
    foreach (d[i]) begin
      master.send_byte(d[i], a);
      check(a, exp_ack);
    end
    master.bus_stop();
  endtask

  task automatic read_seq(input logic [7:0] aw, input logic [15:0] ptr,
                          input logic [7:0] exp[$]);
    logic a;
    logic [7:0] b;
    // Pointer load, then a repeated start without a stop in between.
    master.bus_start();
    master.send_byte(aw, a);
    check(a, 1'b0);
    master.send_byte(ptr[15:8], a);
    check(a, 1'b0);
    master.send_byte(ptr[7:0], a);
    check(a, 1'b0);
    master.bus_start();
    master.send_byte(aw | 8'h01, a);
    check(a, 1'b0);
    foreach (exp[i]) begin
      master.recv_byte(i == exp.size() - 1, b);
      check(b, exp[i]);
    end
    master.bus_stop();
  endtask

  // The master picks the address pair with the interrupt line at reset release.
  task automatic select_pair(input logic hi);
    @(posedge clk_i);
    rst_line_n <= 1'b0;
    int_drive <= 1'b1;
    int_val <= hi;
    master.wait_clk(8);
    rst_line_n <= 1'b1;
    master.wait_clk(8);
    int_drive <= 1'b0;
    master.wait_clk(4);
    check(addr_sel_o, hi);
  endtask

  // =====================================================================
  // Scenarios

  task automatic t_reset();
    check(sda_oe_o, 1'b0);
    check(sda_o, 1'b0);
    check(int_oe_o, 1'b0);
    check(int_o, 1'b0);
    check(addr_sel_o, 1'b0);
    check(config_version_o, 8'h00);
    check(x_max_o, 16'h0000);
  endtask

  task automatic t_write_burst();
    write_seq(8'hba, 16'h8047, {8'h5a, 8'he0, 8'h01, 8'h10, 8'h01, 8'h05, 8'h08}, 1'b0);
    check(config_version_o, 8'h5a);
    check(x_max_o, 16'h01e0);
    check(y_max_o, 16'h0110);
    check(touch_point_limit_o, 4'h5);
    check(swap_axes_o, 1'b1);
    write_seq(8'hba, 16'h8040, {8'h02}, 1'b0);
    check(command_o, 8'h02);
  endtask

  task automatic t_read_back();
    read_seq(8'hba, 16'h8046, {8'h00, 8'h5a, 8'he0, 8'h01, 8'h10, 8'h01, 8'h05, 8'h08});
    read_seq(8'hba, 16'h8040, {8'h00});
  endtask

  task automatic t_wrong_addr();
    seen_oe = 1'b0;
    master.bus_start();
    write_seq(8'ha0, 16'h8047, {8'h77}, 1'b1);
    check(seen_oe, 1'b0);
    check(config_version_o, 8'h5a);
  endtask

  task automatic t_pair_b();
    select_pair(1'b1);
    write_seq(8'h28, 16'h8047, {8'h33}, 1'b0);
    check(config_version_o, 8'h33);
    write_seq(8'hba, 16'h8047, {8'h44}, 1'b1);
    read_seq(8'h28, 16'h8047, {8'h33, 8'he0});
    select_pair(1'b0);
    write_seq(8'h28, 16'h8047, {8'h55}, 1'b1);
    read_seq(8'hba, 16'h8047, {8'h33});
  endtask

  // =====================================================================
  // Sequence

  initial begin
    clk_i = 1'b0;
    srst_i = 1'b1;
    rst_line_n = 1'b0;
    int_drive = 1'b1;
    int_val = 1'b0;
    prev_scl = 1'b1;
    prev_oe = 1'b0;
    seen_oe = 1'b0;
    master.wait_clk(16);
    srst_i <= 1'b0;
    master.wait_clk(8);
    rst_line_n <= 1'b1;
    master.wait_clk(8);
    int_drive <= 1'b0;
    master.wait_clk(8);
    t_reset();
    t_write_burst();
    t_read_back();
    t_wrong_addr();
    t_pair_b();
    stop_test();
  end

  // Cuts the run short if a sequence hangs.
  initial begin
    #(20000 * 40);
    n_mismatch++;
    stop_test();
  end
endmodule

// ### tb/tsi_master_model.sv
// Purpose: Bus master that drives the touch controller's serial port.
// Assumes: Bit period is 8 clocks, 6 low and 2 high, so the slave answers in the low phase.
// Notes: Data line is open drain; sda_low_o high pulls it low.

module tsi_master_model (
  // Clock
  input wire logic clk_i,
  // Bus lines
  input wire logic sda_line_i,
  output logic scl_o,
  output logic sda_low_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // =====================================================================
  // Conditions

  // Data falls while the clock stays high; also serves as repeated start.
  task automatic bus_start();
    wait_clk(3);
    sda_low_o <= 1'b0;
    wait_clk(3);
    scl_o <= 1'b1;
    wait_clk(4);
    sda_low_o <= 1'b1;
    wait_clk(4);
    scl_o <= 1'b0;
  endtask

  task automatic bus_stop();
    wait_clk(3);
    sda_low_o <= 1'b1;
    wait_clk(3);
    scl_o <= 1'b1;
    wait_clk(4);
    sda_low_o <= 1'b0;
    wait_clk(4);
  endtask

  // =====================================================================
  // Bits and bytes

  // Data changes mid low phase and is sampled at the end of the high phase.
  task automatic clock_bit(input logic b, output logic seen);
    wait_clk(3);
    sda_low_o <= !b;
    wait_clk(3);
    scl_o <= 1'b1;
    wait_clk(2);
    seen = sda_line_i;
    scl_o <= 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b[i], s);
    end
    clock_bit(1'b1, ack);
  endtask

  // The last byte of a read is answered with a not-acknowledge.
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, s);
      b[i] = s;
    end
    clock_bit(last, s);
  endtask
endmodule
